// ==== pfbm_pkg.sv ====
// package for the parallel flash bus controller: register map, pin timing, types
`default_nettype none
package pfbm_pkg;
	localparam int CLK_MHZ = 125;
	// pin timings in ns
	localparam int ADDR_ACCESS_NS = 70;
	localparam int SELECT_ACCESS_NS = 70;
	localparam int WRITE_PULSE_NS = 40;
	localparam int WRITE_RECOVER_NS = 30;
	localparam int MIN_RESET_PULSE_NS = 500;
	localparam int RESET_RECOVERY_NS = 50;
	localparam int RESET_READY_NS = 20000;
	localparam int SLEEP_EXTRA_NS = 30;
	// cycle counts, least times rounded up
	localparam int ACCESS_CYC = (SELECT_ACCESS_NS * CLK_MHZ + 999) / 1000 + 1;
	localparam int WPULSE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int WREC_CYC = (WRITE_RECOVER_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_PULSE_CYC = (MIN_RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_REC_CYC = (RESET_RECOVERY_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_READY_CYC = (RESET_READY_NS * CLK_MHZ + 999) / 1000;
	localparam int SLEEP_CYC = ((ADDR_ACCESS_NS + SLEEP_EXTRA_NS) * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 16;
	// flash geometry
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int BANK_LSB = 20;
	// host register byte offsets
	localparam logic [3:0] REG_ADDR = 4'h0;
	localparam logic [3:0] REG_WDATA = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;
	localparam logic [3:0] REG_RDATA = 4'h0;
	// control register fields
	localparam int CTRL_GO_RD = 0;
	localparam int CTRL_GO_WR = 1;
	localparam int CTRL_GO_RST = 2;
	localparam int CTRL_WORD = 3;
	localparam int CTRL_PROTECT_HI = 4;
	localparam int CTRL_BOOST = 5;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
	// status fields
	localparam int ST_BUSY = 0;
	localparam int ST_READY = 1;
	localparam int ST_DONE = 2;
	localparam int ST_SLEEP = 3;
	localparam int ST_BOOST = 4;
	typedef enum logic [2:0] {PFBM_IDLE, PFBM_READ, PFBM_WRITE, PFBM_WREC, PFBM_RST, PFBM_RREC} pfbm_state_e;
	// pins toward the flash
	typedef struct packed {
		logic select_n;
		logic out_gate_n;
		logic write_n;
		logic reset_n;
		logic word_mode;
		logic protect_boost_pin;
		logic boost_voltage_level;
		logic [ADDR_W-1:0] addr;
	} pfbm_pins_s;
endpackage : pfbm_pkg
`default_nettype wire

// ==== pfbm_sync.sv ====
// two-flop synchroniser for pins entering the clock domain
`default_nettype none
module pfbm_sync import pfbm_pkg::*; #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s1_d;
	logic [W-1:0] s2_d;
	// first stage is read only by the second
	always_comb begin
		s1_d = din;
		s2_d = s1_q;
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s1_q <= '0;
			dout <= '0;
		end else begin
			s1_q <= s1_d;
			dout <= s2_d;
		end
	end
endmodule : pfbm_sync
`default_nettype wire

// ==== pfbm_ctrl.sv ====
// host-side controller driving a parallel flash through its bus pins
// Notes on behaviour
// - reads drive select and output gate low, write strobe high.
// - writes drive write strobe and select low, output gate high.
// - fast program mode needs two write cycles, not four.
// - boost only during accelerated programming (here boost follows CTRL_BOOST in any state); protect pin never floats.
// - wait recovery time after reset before reading; restart interrupted work (here the controller restarts nothing; CTRL_GO_RST is taken only while idle).
`default_nettype none
module pfbm_ctrl import pfbm_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output var pfbm_pins_s pins,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic [DATA_W-1:0] data_oe_n,
	input wire logic ready_busy_n
);
	logic [ADDR_W-1:0] faddr_q, faddr_d;
	logic [DATA_W-1:0] fwdata_q, fwdata_d, frdata_q, frdata_d;
	logic [31:0] ctrl_q, ctrl_d, rdata_d;
	pfbm_state_e st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, idle_q, idle_d;
	logic done_q, done_d, sleep_q, sleep_d;
	pfbm_pins_s pins_d;
	logic [DATA_W-1:0] dout_d, doe_n_d;
	logic [DATA_W-1:0] din_s;
	logic rb_s;
	logic busy;

	// pins from the flash cross into our clock first
	pfbm_sync #(.W(DATA_W)) u_sync_data (.clock(clock), .rst_n(rst_n), .din(data_in), .dout(din_s));
	pfbm_sync #(.W(1)) u_sync_rb (.clock(clock), .rst_n(rst_n), .din(ready_busy_n), .dout(rb_s));

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n);
	endfunction : cyc

	assign busy = (st_q != PFBM_IDLE);

	// register file and sequencer next state
	always_comb begin
		faddr_d = faddr_q;
		fwdata_d = fwdata_q;
		frdata_d = frdata_q;
		ctrl_d = ctrl_q;
		st_d = st_q;
		cnt_d = cnt_q;
		done_d = done_q;
		rdata_d = '0;
		idle_d = idle_q;
		sleep_d = sleep_q;
		// software writes; go bits are taken only while idle so a transfer cannot be torn
		if (wr) begin
			case (addr)
				REG_ADDR: faddr_d = wdata[ADDR_W-1:0];
				REG_WDATA: fwdata_d = wdata[DATA_W-1:0];
				REG_CTRL: begin
					ctrl_d = wdata;
					ctrl_d[CTRL_GO_RD] = 1'b0;
					ctrl_d[CTRL_GO_WR] = 1'b0;
					ctrl_d[CTRL_GO_RST] = 1'b0;
					if (!busy) begin
						if (wdata[CTRL_GO_RST]) begin
							st_d = PFBM_RST;
							cnt_d = cyc(RST_PULSE_CYC);
							done_d = 1'b0;
						end else if (wdata[CTRL_GO_WR]) begin
							// one go is one bus write cycle, so a fast program is two go writes
							st_d = PFBM_WRITE;
							cnt_d = cyc(WPULSE_CYC);
							done_d = 1'b0;
						end else if (wdata[CTRL_GO_RD]) begin
							st_d = PFBM_READ;
							cnt_d = cyc(ACCESS_CYC);
							done_d = 1'b0;
						end
					end
				end
				default: ;
			endcase
		end
		// done is sticky; reading status clears it unless a transfer ends in the same cycle
		if (rd) begin
			case (addr)
				REG_RDATA: rdata_d = {{(32-DATA_W){1'b0}}, frdata_q};
				REG_CTRL: rdata_d = ctrl_q;
				REG_STATUS: begin
					rdata_d[ST_BUSY] = busy;
					rdata_d[ST_READY] = rb_s;
					rdata_d[ST_DONE] = done_q;
					rdata_d[ST_SLEEP] = sleep_q;
					rdata_d[ST_BOOST] = ctrl_q[CTRL_BOOST];
					done_d = 1'b0;
				end
				default: rdata_d = '0;
			endcase
		end
		// sequencer
		case (st_q)
			PFBM_IDLE: ;
			PFBM_READ: begin
				if (cnt_q <= cyc(1)) begin
					// byte mode returns only the low lane
					frdata_d = ctrl_q[CTRL_WORD] ? din_s : {8'h00, din_s[7:0]};
					st_d = PFBM_IDLE;
					done_d = 1'b1;
				end else begin
					cnt_d = cnt_q - cyc(1);
				end
			end
			PFBM_WRITE: begin
				if (cnt_q <= cyc(1)) begin
					st_d = PFBM_WREC;
					cnt_d = cyc(WREC_CYC);
				end else begin
					cnt_d = cnt_q - cyc(1);
				end
			end
			PFBM_WREC, PFBM_RREC: begin
				if (cnt_q <= cyc(1)) begin
					st_d = PFBM_IDLE;
					done_d = 1'b1;
				end else begin
					cnt_d = cnt_q - cyc(1);
				end
			end
			PFBM_RST: begin
				// hold reset at least the pulse width, then until flash reports ready
				if (cnt_q > cyc(1)) begin
					cnt_d = cnt_q - cyc(1);
				end else if (rb_s) begin
					st_d = PFBM_RREC;
					cnt_d = cyc(RST_REC_CYC);
				end
			end
			default: st_d = PFBM_IDLE;
		endcase
		// stable address tracking mirrors the flash's sleep entry
		if (faddr_d != faddr_q) begin
			idle_d = '0;
			sleep_d = 1'b0;
		end else if (idle_q >= cyc(SLEEP_CYC)) begin
			sleep_d = 1'b1;
		end else begin
			idle_d = idle_q + cyc(1);
		end
	end

	// pin drive next state
	always_comb begin
		pins_d.select_n = !(st_d == PFBM_READ || st_d == PFBM_WRITE);
		pins_d.out_gate_n = !(st_d == PFBM_READ);
		pins_d.write_n = !(st_d == PFBM_WRITE);
		pins_d.reset_n = !(st_d == PFBM_RST);
		pins_d.word_mode = ctrl_d[CTRL_WORD];
		// boost only with the protect pin also driven, never floating
		pins_d.protect_boost_pin = ctrl_d[CTRL_PROTECT_HI] | ctrl_d[CTRL_BOOST];
		pins_d.boost_voltage_level = ctrl_d[CTRL_BOOST];
		pins_d.addr = faddr_d;
		dout_d = fwdata_d;
		doe_n_d = '1;
		if (st_d == PFBM_WRITE || st_d == PFBM_WREC) begin
			doe_n_d = ctrl_d[CTRL_WORD] ? '0 : {8'hff, 8'h00};
		end
		// in byte mode line 15 carries the low address bit at all times
		if (!ctrl_d[CTRL_WORD]) begin
			dout_d[DATA_W-1] = faddr_d[0];
			doe_n_d[DATA_W-1] = 1'b0;
			pins_d.addr = {1'b0, faddr_d[ADDR_W-1:1]};
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			faddr_q <= '0;
			fwdata_q <= '0;
			frdata_q <= '0;
			ctrl_q <= CTRL_RESET;
			st_q <= PFBM_IDLE;
			cnt_q <= '0;
			done_q <= 1'b0;
			idle_q <= '0;
			sleep_q <= 1'b0;
			rdata <= '0;
			pins <= '{select_n: 1'b1, out_gate_n: 1'b1, write_n: 1'b1, reset_n: 1'b1,
				word_mode: 1'b1, protect_boost_pin: 1'b0, boost_voltage_level: 1'b0, addr: '0};
			data_out <= '0;
			data_oe_n <= '1;
		end else begin
			faddr_q <= faddr_d;
			fwdata_q <= fwdata_d;
			frdata_q <= frdata_d;
			ctrl_q <= ctrl_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			idle_q <= idle_d;
			sleep_q <= sleep_d;
			rdata <= rdata_d;
			pins <= pins_d;
			data_out <= dout_d;
			data_oe_n <= doe_n_d;
		end
	end
endmodule : pfbm_ctrl
`default_nettype wire

// ==== pfbm_flash_model.sv ====
// behavioural flash on the far side of the controller
`default_nettype none
module pfbm_flash_model import pfbm_pkg::*; #(
	parameter int READY_CYC = 200
) (
	input wire logic clock,
	input var pfbm_pins_s pins,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic [DATA_W-1:0] data_oe_n,
	output logic [DATA_W-1:0] data_in,
	output logic ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] last_q = '0, wd_q;
	logic [ADDR_W-1:0] wa_q;
	logic wn_q = 1'b1;
	logic rn_q = 1'b1;
	int busy_q = 0;
	int n_wr_q = 0;
	wire logic [DATA_W-1:0] arr_w = pins.addr[15:0] ^ 16'h5a5a;
	// floating lines show the inverse of the last level, so stale data never passes
	always_comb begin
		if (!pins.select_n && !pins.out_gate_n && pins.reset_n && pins.write_n)
			data_in = pins.word_mode ? arr_w : {data_out[15], ~last_q[14:8], data_out[15] ? arr_w[15:8] : arr_w[7:0]};
		else
			data_in = (data_out & ~data_oe_n) | (~last_q & data_oe_n);
	end
	assign ready_busy_n = (busy_q == 0);
	// write capture on the strobe's rising edge, busy held through internal reset
	always_ff @(posedge clock) begin
		last_q <= data_in;
		wn_q <= pins.write_n;
		rn_q <= pins.reset_n;
		// the captured address holds the bank and sector bits an erase or suspended access aims at
		if (!wn_q && pins.write_n) begin
			wa_q <= pins.addr;
			wd_q <= data_in; // undriven lines land as the inverse of their last level
			n_wr_q <= n_wr_q + 1;
		end
		// busy starts when reset falls and runs out on its own, or a held reset would never end
		if (rn_q && !pins.reset_n)
			busy_q <= READY_CYC;
		else if (busy_q > 0)
			busy_q <= busy_q - 1;
	end
endmodule : pfbm_flash_model
`default_nettype wire

// ==== pfbm_ctrl_props.sv ====
// assertions on the controller's pins and register port
`default_nettype none
module pfbm_ctrl_props import pfbm_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input var pfbm_pins_s pins,
	input wire logic [DATA_W-1:0] data_oe_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [CNT_W-1:0] low_q, low_d;
	// counts the reset pulse so its width is judged at release
	always_comb low_d = pins.reset_n ? '0 : low_q + 1'b1;
	always_ff @(posedge clock) low_q <= low_d;
	sequence strobe_low; !pins.write_n [*5]; endsequence
	sequence gate_quiet; pins.out_gate_n [*7]; endsequence
	read_levels_a: assert property (!pins.select_n && !pins.out_gate_n |-> pins.write_n) else $error("read strobe");
	write_levels_a: assert property (!pins.write_n |-> !pins.select_n && pins.out_gate_n) else $error("write levels");
	no_contend_a: assert property (!pins.out_gate_n |-> &data_oe_n[14:0]) else $error("drives while gated");
	byte_float_a: assert property (!pins.word_mode |-> &data_oe_n[14:8]) else $error("byte lines driven");
	write_width_a: assert property ($fell(pins.write_n) |-> strobe_low ##1 pins.write_n) else $error("write width");
	rst_width_a: assert property ($rose(pins.reset_n) |-> low_q >= RST_PULSE_CYC) else $error("reset short");
	rst_quiet_a: assert property (!pins.reset_n |-> pins.select_n && pins.write_n) else $error("bus in reset");
	rst_recover_a: assert property ($rose(pins.reset_n) |-> gate_quiet) else $error("early read");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == '0) else $error("rdata not idle");
	boost_driven_a: assert property (pins.boost_voltage_level |-> pins.protect_boost_pin) else $error("boost floats");
endmodule : pfbm_ctrl_props
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the flash bus controller
`default_nettype none
module testbench import pfbm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst_n = 0, wr = 0, rd = 0;
	logic [3:0] addr = '0;
	logic [31:0] wdata = '0, rdata, r;
	pfbm_pins_s pins;
	logic [DATA_W-1:0] data_in, data_out, data_oe_n;
	logic ready_busy_n;
	int n_mismatch = 0, check_count = 0;
	localparam int FLASH_READY_CYC = 200;
	always #4 clock = ~clock;
	pfbm_ctrl u_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pins(pins), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .ready_busy_n(ready_busy_n));
	pfbm_flash_model #(.READY_CYC(FLASH_READY_CYC)) u_flash (.clock(clock), .pins(pins), .data_out(data_out),
		.data_oe_n(data_oe_n),
		.data_in(data_in), .ready_busy_n(ready_busy_n));
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one strobe cycle then a gap, so back-to-back calls never double-assign
	task automatic reg_wr(logic [3:0] a, logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		@(posedge clock);
	endtask : reg_wr
	task automatic reg_rd(logic [3:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 r = rdata;
		@(posedge clock);
	endtask : reg_rd
	task automatic go(logic [31:0] c);
		reg_wr(REG_CTRL, c);
		for (int i = 0; i < 400; i++) begin
			reg_rd(REG_STATUS);
			if (r[ST_BUSY] === 1'b0)
				break;
		end
		chk("done", 32'h1, 32'(r[ST_DONE]));
	endtask : go
	task automatic t_read(logic w, logic [21:0] a);
		logic [15:0] v;
		v = (w ? a[15:0] : a[16:1]) ^ 16'h5a5a;
		reg_wr(REG_ADDR, 32'(a));
		go((32'(w) << CTRL_WORD) | (32'h1 << CTRL_GO_RD));
		reg_rd(REG_RDATA);
		if (w)
			chk("word", 32'(v), r);
		else
			chk("byte", 32'(a[0] ? v[15:8] : v[7:0]), r);
		$display("read test done");
	endtask : t_read
	// a fast program pair of word writes, then one byte write
	task automatic t_write();
		int n0;
		n0 = u_flash.n_wr_q;
		reg_wr(REG_ADDR, 32'h0000_0555);
		reg_wr(REG_WDATA, 32'h0000_00a0);
		go((32'h1 << CTRL_WORD) | (32'h1 << CTRL_GO_WR));
		reg_wr(REG_ADDR, 32'h0010_0055);
		reg_wr(REG_WDATA, 32'h0000_c3a5);
		go((32'h1 << CTRL_WORD) | (32'h1 << CTRL_GO_WR));
		chk("prog cycles", 32'h2, 32'(u_flash.n_wr_q - n0));
		chk("prog addr", 32'h0010_0055, 32'(u_flash.wa_q));
		chk("prog bank", 32'h1, 32'(u_flash.wa_q[ADDR_W-1:BANK_LSB]));
		chk("prog data", 32'h0000_c3a5, 32'(u_flash.wd_q));
		reg_wr(REG_ADDR, 32'h0000_0abd);
		reg_wr(REG_WDATA, 32'h0000_0077);
		go(32'h1 << CTRL_GO_WR);
		chk("byte prog addr", 32'h0000_055e, 32'(u_flash.wa_q));
		chk("byte prog data", 32'h0000_0077, 32'(u_flash.wd_q[7:0]));
		chk("byte addr line", 32'h1, 32'(u_flash.wd_q[DATA_W-1]));
		$display("write test done");
	endtask : t_write
	// boost level only with the protect pin driven, and removable
	task automatic t_boost();
		reg_wr(REG_CTRL, 32'h1 << CTRL_WORD);
		chk("protect low", 32'h0, 32'(pins.protect_boost_pin));
		reg_wr(REG_CTRL, (32'h1 << CTRL_WORD) | (32'h1 << CTRL_BOOST));
		chk("boost level", 32'h1, 32'(pins.boost_voltage_level));
		chk("boost pin", 32'h1, 32'(pins.protect_boost_pin));
		reg_rd(REG_STATUS);
		chk("boost status", 32'h1, 32'(r[ST_BOOST]));
		reg_wr(REG_CTRL, 32'h1 << CTRL_WORD);
		chk("boost off", 32'h0, 32'(pins.boost_voltage_level));
		$display("boost test done");
	endtask : t_boost
	// a new address wakes the flash; a stable one puts it asleep
	task automatic t_sleep();
		reg_wr(REG_ADDR, 32'h0000_0123);
		reg_rd(REG_STATUS);
		chk("awake", 32'h0, 32'(r[ST_SLEEP]));
		repeat (SLEEP_CYC) @(posedge clock);
		reg_rd(REG_STATUS);
		chk("asleep", 32'h1, 32'(r[ST_SLEEP]));
		$display("sleep test done");
	endtask : t_sleep
	task automatic t_reset();
		realtime t0;
		t0 = $realtime;
		go((32'h1 << CTRL_WORD) | (32'h1 << CTRL_GO_RST));
		// the pulse overlaps the flash's busy time, recovery follows it
		chk("reset wait", 32'h1, 32'(($realtime - t0) >= 8 * (FLASH_READY_CYC + RST_REC_CYC)));
		chk("ready", 32'h1, 32'(r[ST_READY]));
		t_read(1'b1, 22'h00_0010);
		$display("reset test done");
	endtask : t_reset
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	// main sequence
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		reg_rd(REG_CTRL);
		chk("ctrl reset", CTRL_RESET, r);
		t_read(1'b1, 22'h01_2345);
		t_read(1'b0, 22'h00_0ab3);
		t_read(1'b0, 22'h00_0ab2);
		t_write();
		t_reset();
		t_boost();
		t_sleep();
		test_done();
	end
	// watchdog: the whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		test_done();
	end
endmodule : testbench
bind pfbm_ctrl pfbm_ctrl_props u_props (.clock(clock), .rst_n(rst_n), .rd(rd), .rdata(rdata), .pins(pins),
	.data_oe_n(data_oe_n));
`default_nettype wire
